// *** shared/fpdec_consts.vh ***
// Constants for the coprocessor instruction decoder
`ifndef FPDEC_CONSTS_VH
`define FPDEC_CONSTS_VH
// Register byte offsets
`define FPDEC_OFF_INSTR  8'h00
`define FPDEC_OFF_OPND   8'h04
`define FPDEC_OFF_STAT   8'h08
`define FPDEC_OFF_CTRL   8'h0C
`define FPDEC_OFF_DEC    8'h10
`define FPDEC_OFF_RES    8'h14
// Instruction word constants
`define FPDEC_LINE_F     4'hF
`define FPDEC_CPID       3'h1
`define FPDEC_OP_SUB     7'h28
`define FPDEC_OP_SSUB    7'h68
`define FPDEC_OP_DSUB    7'h6C
`define FPDEC_OP_TAN     7'h0F
`define FPDEC_OP_TANH    7'h09
// Effective address modes
`define FPDEC_EA_DREG    3'h0
`define FPDEC_EA_AREG    3'h1
`define FPDEC_EA_EXT     3'h7
`define FPDEC_EXT_ABSW   3'h0
`define FPDEC_EXT_ABSL   3'h1
`define FPDEC_EXT_PCD    3'h2
`define FPDEC_EXT_PCX    3'h3
`define FPDEC_EXT_IMM    3'h4
// Source formats
`define FPDEC_FMT_L      3'h0
`define FPDEC_FMT_S      3'h1
`define FPDEC_FMT_P      3'h3
`define FPDEC_FMT_W      3'h4
`define FPDEC_FMT_B      3'h6
`define FPDEC_FMT_BAD    3'h7
// Operand classes
`define FPDEC_CL_NORM    2'h0
`define FPDEC_CL_ZERO    2'h1
`define FPDEC_CL_INF     2'h2
`define FPDEC_CL_NAN     2'h3
// Special result kinds
`define FPDEC_RK_CALC    2'h0
`define FPDEC_RK_ZERO    2'h1
`define FPDEC_RK_ONE     2'h2
`define FPDEC_RK_NAN     2'h3
// Rounding precision codes
`define FPDEC_PR_SGL     2'h1
`define FPDEC_PR_DBL     2'h2
`define FPDEC_STAT_RST   32'h00000000
`define FPDEC_ZERO32     32'h00000000
`endif

// *** design/fpdec_top.v ***
// Decoder and status unit for subtract, tangent and hyperbolic tangent
`timescale 1ns/1ps
`include "fpdec_consts.vh"
module fpdec_top (
   // APB clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB request
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   // APB answer
   output reg         pready,
   output reg  [31:0] prdata,
   output reg         pslverr,
   // Execution strobe to the arithmetic datapath
   output reg         op_start,
   output reg  [4:0]  op_select
);

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------

   // Formats that fit in a data register
   function small_fmt;
      input [2:0] f;
      begin
         small_fmt = (f == `FPDEC_FMT_L) | (f == `FPDEC_FMT_S) |
                     (f == `FPDEC_FMT_W) | (f == `FPDEC_FMT_B);
      end
   endfunction

   // Opcode compare with the fixed zero bits of word two
   function op_is;
      input [15:0] w;
      input [6:0]  code;
      begin
         op_is = ~w[15] & ~w[13] & (w[6:0] == code);
      end
   endfunction

   // Completed write aimed at one register offset
   function wr_at;
      input       w;
      input [7:0] a;
      input [7:0] off;
      begin
         wr_at = w & (a == off);
      end
   endfunction

   // Operand class compare, shared by result and exception logic
   function cls_is;
      input [1:0] c;
      input [1:0] k;
      begin
         cls_is = (c == k);
      end
   endfunction

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   reg  [31:0] instr_reg;
   reg  [12:0] opnd_reg;
   reg  [31:0] stat_reg;
   reg  [1:0]  ctrl_reg;
   reg  [23:0] dec_reg;
   reg  [3:0]  res_reg;

   // Transfer completes on this edge
   wire        xfer;
   wire        wr;
   assign xfer = psel & penable & pready;
   assign wr   = xfer & pwrite;

   // ------------------------------------------------------------
   // Instruction fields
   // ------------------------------------------------------------
   wire [15:0] w1;
   wire [15:0] w2;
   wire        rm;
   wire [2:0]  spec;
   wire [2:0]  dst;
   wire [2:0]  ea_m;
   wire [2:0]  ea_r;
   assign w1   = pwdata[31:16];
   assign w2   = pwdata[15:0];
   assign rm   = w2[14];
   assign spec = w2[12:10];
   assign dst  = w2[9:7];
   assign ea_m = w1[5:3];
   assign ea_r = w1[2:0];

   // Operand description fields
   wire [1:0]  cls;
   wire        sgn;
   wire        big;
   wire        dneg;
   wire        dzero;
   wire        like_inf;
   wire        f_overflow_flag;
   wire        f_underflow_flag;
   wire        f_result_inexact_flag;
   wire        f_signaling_nan_flag;
   wire        f_decimal_input_inexact_flag;
   assign cls      = opnd_reg[1:0];
   assign sgn      = opnd_reg[2];
   assign big      = opnd_reg[3];
   assign like_inf = opnd_reg[4];
   assign dneg     = opnd_reg[5];
   assign dzero    = opnd_reg[6];
   assign f_overflow_flag   = opnd_reg[8];
   assign f_underflow_flag   = opnd_reg[9];
   assign f_result_inexact_flag  = opnd_reg[10];
   assign f_signaling_nan_flag   = opnd_reg[11];
   assign f_decimal_input_inexact_flag  = opnd_reg[12];

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------

   // Coprocessor header check
   wire hdr_ok;
   assign hdr_ok = (w1[15:12] == `FPDEC_LINE_F) &
                   (w1[11:9] == `FPDEC_CPID) &
                   (w1[8:6] == 3'h0);

   // Operation one-hot: sub, ssub, dsub, tan, tanh
   wire is_sub;
   wire is_ssub;
   wire is_dsub;
   wire is_tan;
   wire is_tanh;
   assign is_sub  = op_is(w2, `FPDEC_OP_SUB);
   assign is_ssub = op_is(w2, `FPDEC_OP_SSUB);
   assign is_dsub = op_is(w2, `FPDEC_OP_DSUB);
   assign is_tan  = op_is(w2, `FPDEC_OP_TAN);
   assign is_tanh = op_is(w2, `FPDEC_OP_TANH);

   // Address mode legality, only when memory form
   reg ea_ok;
   always @* begin
      case (ea_m)
         `FPDEC_EA_DREG: ea_ok = small_fmt(spec);
         `FPDEC_EA_AREG: ea_ok = 1'b0;
         `FPDEC_EA_EXT: begin
            case (ea_r)
               `FPDEC_EXT_ABSW: ea_ok = 1'b1;
               `FPDEC_EXT_ABSL: ea_ok = 1'b1;
               `FPDEC_EXT_PCD:  ea_ok = 1'b1;
               `FPDEC_EXT_PCX:  ea_ok = 1'b1;
               `FPDEC_EXT_IMM:  ea_ok = 1'b1;
               default:         ea_ok = 1'b0;
            endcase
         end
         default: ea_ok = 1'b1;
      endcase
   end

   // Legal instruction; register form ignores the address field
   wire any_op;
   wire legal;
   assign any_op = is_sub | is_ssub | is_dsub | is_tan | is_tanh;
   assign legal  = hdr_ok & any_op &
                   (~rm | (ea_ok & (spec != `FPDEC_FMT_BAD)));

   // Precision: extended unless subtract variant picks one
   wire [1:0] prec;
   assign prec = is_ssub ? `FPDEC_PR_SGL :
                 is_dsub ? `FPDEC_PR_DBL :
                 is_sub  ? ctrl_reg : 2'h0;

   // Same register in register form reads and writes one register
   wire same;
   assign same = ~rm & (spec == dst);

   // ------------------------------------------------------------
   // Special results
   // ------------------------------------------------------------
   reg [1:0] rkind;
   reg       rsign;
   always @* begin
      rkind = `FPDEC_RK_CALC;
      rsign = sgn;
      if (cls_is(cls, `FPDEC_CL_NAN)) begin
         rkind = `FPDEC_RK_NAN;
      end else if (cls_is(cls, `FPDEC_CL_ZERO)) begin
         rkind = `FPDEC_RK_ZERO;
      end else if (cls_is(cls, `FPDEC_CL_INF)) begin
         if (is_tan) begin
            rkind = `FPDEC_RK_NAN;
         end else if (is_tanh) begin
            rkind = `FPDEC_RK_ONE;
         end
      end
      if (rkind == `FPDEC_RK_CALC) begin
         rsign = dneg;
      end
   end

   // Tangent argument reduction request
   wire reduce;
   assign reduce = is_tan & cls_is(cls, `FPDEC_CL_NORM) & big;

   // ------------------------------------------------------------
   // Exception byte
   // ------------------------------------------------------------
   wire       src_inf;
   wire       decimal_input_inexact_flag_v;
   reg        x_operand_error_flag;
   reg        x_overflow_flag;
   wire [7:0] exc;
   assign src_inf = cls_is(cls, `FPDEC_CL_INF);
   assign decimal_input_inexact_flag_v = rm & (spec == `FPDEC_FMT_P) & f_decimal_input_inexact_flag;

   // Per-instruction operand error and overflow
   always @* begin
      x_operand_error_flag = like_inf;
      x_overflow_flag  = f_overflow_flag;
      if (is_tan) begin
         x_operand_error_flag = src_inf;
      end
      if (is_tanh) begin
         x_operand_error_flag = 1'b0;
         x_overflow_flag  = 1'b0;
      end
   end

   // Unordered branch and divide by zero always clear
   assign exc = {1'b0, f_signaling_nan_flag, x_operand_error_flag, x_overflow_flag,
                 f_underflow_flag, 1'b0, f_result_inexact_flag, decimal_input_inexact_flag_v};

   // ------------------------------------------------------------
   // Condition and accrued bytes
   // ------------------------------------------------------------
   wire       r_nan;
   wire       r_zero;
   wire [7:0] ccb;
   wire [7:0] acc;
   assign r_nan  = (rkind == `FPDEC_RK_NAN);
   assign r_zero = (rkind == `FPDEC_RK_ZERO) |
                   ((rkind == `FPDEC_RK_CALC) & dzero);
   // Infinity only reaches subtract; it passes through there
   assign ccb = {4'h0, rsign & ~r_nan, r_zero,
                 src_inf & ~is_tan & ~is_tanh, r_nan};
   // Accrued bits only ever set, never cleared by an operation
   assign acc = stat_reg[7:0] |
                {exc[7] | exc[6] | exc[5], exc[4], exc[3] & exc[1],
                 exc[2], exc[1] | exc[0] | exc[4], 3'h0};

   // ------------------------------------------------------------
   // APB answer timing
   // ------------------------------------------------------------

   // Access phase not yet answered; all answer flops key off it
   wire ans_due;
   assign ans_due = psel & penable & ~pready;

   // One wait state keeps pready a plain flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= ans_due;
      end
   end

   // Address decode
   reg        hit;
   reg [31:0] rd_mux;
   always @* begin
      hit    = 1'b1;
      rd_mux = `FPDEC_ZERO32;
      case (paddr)
         `FPDEC_OFF_INSTR: rd_mux = instr_reg;
         `FPDEC_OFF_OPND:  rd_mux = {19'h0, opnd_reg};
         `FPDEC_OFF_STAT:  rd_mux = stat_reg;
         `FPDEC_OFF_CTRL:  rd_mux = {30'h0, ctrl_reg};
         `FPDEC_OFF_DEC:   rd_mux = {8'h0, dec_reg};
         `FPDEC_OFF_RES:   rd_mux = {28'h0, res_reg};
         default:          hit = 1'b0;
      endcase
   end

   // Read data and error, valid in the cycle pready is high
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= `FPDEC_ZERO32;
         pslverr <= 1'b0;
      end else begin
         // Parked at zero outside the ready cycle so stale words never leak
         prdata  <= (ans_due & ~pwrite) ? rd_mux : `FPDEC_ZERO32;
         pslverr <= ans_due & ~hit;
      end
   end

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   wire go;
   assign go = wr_at(wr, paddr, `FPDEC_OFF_INSTR);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_reg <= `FPDEC_ZERO32;
         opnd_reg  <= 13'h0;
         ctrl_reg  <= 2'h0;
      end else begin
         if (go) begin
            instr_reg <= pwdata;
         end
         if (wr_at(wr, paddr, `FPDEC_OFF_OPND)) begin
            opnd_reg <= pwdata[12:0];
         end
         if (wr_at(wr, paddr, `FPDEC_OFF_CTRL)) begin
            ctrl_reg <= pwdata[1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Execution: decode, result kind and status update
   // ------------------------------------------------------------

   // Illegal words leave status untouched; decode shows why
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dec_reg   <= 24'h0;
         res_reg   <= 4'h0;
         stat_reg  <= `FPDEC_STAT_RST;
         op_start  <= 1'b0;
         op_select <= 5'h0;
      end else begin
         op_start <= go & legal;
         if (go) begin
            dec_reg <= {legal, same, prec, rm, spec, dst,
                        ea_m, ea_r, 2'h0,
                        is_tanh, is_tan, is_dsub, is_ssub, is_sub};
            if (legal) begin
               op_select <= {is_tanh, is_tan, is_dsub, is_ssub, is_sub};
               res_reg   <= {reduce, rsign, rkind};
               // Quotient byte kept as is
               stat_reg  <= {ccb, stat_reg[23:16], exc, acc};
            end
         end else if (wr_at(wr, paddr, `FPDEC_OFF_STAT)) begin
            stat_reg <= pwdata;
         end
      end
   end

endmodule

// *** bench/fpdec_top_assertions.sv ***
// Port assertions for the instruction decoder and its register slave
`timescale 1ns/1ps
module fpdec_chk (
   // Clock and reset
   input logic        pclk,
   input logic        presetn,
   // Register bus
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [7:0]  paddr,
   input logic        pready,
   input logic [31:0] prdata,
   input logic        pslverr,
   // Execution strobe
   input logic        op_start,
   input logic [4:0]  op_select
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------
   // Bus answer
   // ----------------
   property p_ans; psel && penable && !pready |-> ##[1:2] pready; endproperty
   a_ans: assert property (p_ans) else $error("access not answered");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("ready held too long");
   property p_err; pready |-> pslverr == (paddr > 8'h14 || paddr[1:0] != 2'h0); endproperty
   a_err: assert property (p_err) else $error("error flag wrong for address");
   // Read data is parked at zero so stale words never leak
   property p_idle; !pready |-> prdata == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("read data not parked");
   // ----------------
   // Execution
   // ----------------
   property p_cause; op_start |-> $past(pready) && $past(pwrite) && $past(paddr) == 8'h00; endproperty
   a_cause: assert property (p_cause) else $error("start without instruction write");
   property p_pulse; op_start |=> !op_start; endproperty
   a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
   property p_hot; op_start |-> $onehot(op_select); endproperty
   a_hot: assert property (p_hot) else $error("operation select not one-hot");
   property p_hold; !op_start |-> $stable(op_select); endproperty
   a_hold: assert property (p_hold) else $error("operation select moved alone");
   c_err: cover property (pready && pslverr);
   c_tan: cover property (op_start && op_select == 5'h08);
   c_tanh: cover property (op_start && op_select == 5'h10);
endmodule
bind fpdec_top fpdec_chk fpdec_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .op_start(op_start), .op_select(op_select));

// *** bench/fpdec_host.sv ***
// Host model: issues instruction words and register traffic over the bus
`timescale 1ns/1ps
`include "fpdec_consts.vh"
module fpdec_host (
   // Clock
   input  wire logic        pclk,
   // Request
   output      logic        psel,
   output      logic        penable,
   output      logic        pwrite,
   output      logic [7:0]  paddr,
   output      logic [31:0] pwdata,
   // Answer
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr
);
   // ----------------
   // Transfers
   // ----------------
   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // Request stands until ready is sampled; on release address and data are inverted, not left stale
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'h0; penable <= 1'h0; paddr <= ~a; pwdata <= ~d;
   endtask
   // Instruction pair; address field forced to zero in register form
   function automatic logic [31:0] iw(input logic rm, input logic [2:0] m, r, s, d, input logic [6:0] op);
      iw = {`FPDEC_LINE_F, `FPDEC_CPID, 3'h0, rm ? {m, r} : 6'h00, 1'h0, rm, 1'h0, s, d, op};
   endfunction
endmodule

// *** bench/tb_fp_sub_tan_tanh_decode.sv ***
// Self-checking bench for the subtract, tangent and hyperbolic tangent decoder
`timescale 1ns/1ps
`include "fpdec_consts.vh"
module tb_fp_sub_tan_tanh_decode;
   // ----------------
   // Signals and tables
   // ----------------
   logic        pclk = 1'h0;
   logic        presetn = 1'h0;
   logic        psel, penable, pwrite, pready, pslverr, op_start, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [4:0]  op_select;
   int          mismatches = 0, checks_done = 0, starts = 0, cycles = 0;
   // Plain subtract runs twice to show it follows the control register
   logic [6:0]  ops [0:5] = '{`FPDEC_OP_SUB, `FPDEC_OP_SUB, `FPDEC_OP_SSUB,
                             `FPDEC_OP_DSUB, `FPDEC_OP_TAN, `FPDEC_OP_TANH};
   logic [1:0]  prc [0:5] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h0, 2'h0};
   logic [1:0]  ctl [0:5] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2};
   logic [4:0]  hot [0:5] = '{5'h01, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
   always #5 pclk = ~pclk;
   fpdec_top fpdec_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .op_start(op_start), .op_select(op_select));
   fpdec_host fpdec_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
   // Start pulses counted here; the cycle ceiling cuts a hang short
   always @(posedge pclk) begin
      cycles++;
      if (op_start === 1'h1) starts++;
      if (cycles == 3000) begin
         mismatches++;
         stop_test;
      end
   end
   task automatic chk(input logic [31:0] got, exp, mask);
      checks_done++;
      if ((got & mask) !== (exp & mask)) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got & mask, exp & mask);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      fpdec_host_i.xfer(1'h1, a, d, q, e);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, mask);
      fpdec_host_i.xfer(1'h0, a, 32'h0, q, e);
      chk(q, exp, mask);
   endtask
   // Status preset, operand class, then instruction, then status and result read back
   task automatic sv(input logic [31:0] od, input logic rm, input logic [2:0] s, input logic [6:0] op,
                     input logic [31:0] pre, es, sm, er);
      wr(`FPDEC_OFF_STAT, pre);
      wr(`FPDEC_OFF_OPND, od);
      wr(`FPDEC_OFF_INSTR, fpdec_host_i.iw(rm, 3'h2, 3'h1, s, 3'h5, op));
      rdc(`FPDEC_OFF_STAT, es, sm);
      rdc(`FPDEC_OFF_RES, er, 32'hF);
   endtask
   // Memory-form tangent; refused forms must not start the datapath
   task automatic ea(input logic [2:0] m, r, s, input logic ok);
      int n;
      n = starts;
      wr(`FPDEC_OFF_INSTR, fpdec_host_i.iw(1'h1, m, r, s, 3'h2, `FPDEC_OP_TAN));
      rdc(`FPDEC_OFF_DEC, {8'h0, ok, 4'h1, s, 3'h2, m, r, 7'h0}, ok ? 32'h008FFF80 : 32'h00800000);
      chk(starts - n, {31'h0, ok}, 32'h1);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ----------------
   // Tests
   // ----------------
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      rdc(`FPDEC_OFF_STAT, `FPDEC_STAT_RST, 32'hFFFFFFFF);
      rdc(`FPDEC_OFF_DEC, 32'h0, 32'hFFFFFFFF);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         wr(`FPDEC_OFF_CTRL, {30'h0, ctl[i]});
         wr(`FPDEC_OFF_INSTR, fpdec_host_i.iw(1'h0, 3'h0, 3'h0, 3'h3, 3'h5, ops[i]));
         rdc(`FPDEC_OFF_DEC, {8'h0, 1'h1, 1'h0, prc[i], 15'h0, hot[i]}, 32'h00F0001F);
         chk({27'h0, op_select}, {27'h0, hot[i]}, 32'h1F);
      end
      chk(starts, 6, 32'hFF);
      $display("test opmodes done");
      sv(32'h2, 1'h0, 3'h3, `FPDEC_OP_TAN, 32'h00A58400, 32'h01A52080, 32'hF7FFFFFF, 32'h3);
      sv(32'h5, 1'h0, 3'h3, `FPDEC_OP_TAN, 32'h00A50080, 32'h0CA50080, 32'hFFFFFFFF, 32'h5);
      sv(32'h8, 1'h0, 3'h3, `FPDEC_OP_TAN, 32'h0, 32'h0, 32'hFFFFFFFF, 32'h8);
      sv(32'h106, 1'h0, 3'h3, `FPDEC_OP_TANH, 32'h00008400, 32'h08000000, 32'hFFFFFFFF, 32'h6);
      sv(32'h1, 1'h0, 3'h3, `FPDEC_OP_TANH, 32'h0, 32'h04000000, 32'hFFFFFFFF, 32'h1);
      sv(32'h1000, 1'h1, `FPDEC_FMT_P, `FPDEC_OP_TANH, 32'h0, 32'h108, 32'hFFFFFFFF, 32'h0);
      sv(32'h1000, 1'h1, `FPDEC_FMT_S, `FPDEC_OP_TAN, 32'h0, 32'h0, 32'hFFFFFFFF, 32'h0);
      $display("test special values done");
      ea(3'h1, 3'h0, `FPDEC_FMT_S, 1'h0);
      ea(3'h6, 3'h2, `FPDEC_FMT_L, 1'h1);
      ea(3'h0, 3'h3, `FPDEC_FMT_W, 1'h1);
      ea(3'h0, 3'h3, 3'h5, 1'h0);
      ea(3'h7, 3'h5, `FPDEC_FMT_S, 1'h0);
      for (int k = 0; k < 5; k++) ea(3'h7, k[2:0], `FPDEC_FMT_B, 1'h1);
      ea(3'h2, 3'h1, `FPDEC_FMT_BAD, 1'h0);
      $display("test addressing done");
      wr(`FPDEC_OFF_INSTR, fpdec_host_i.iw(1'h0, 3'h7, 3'h7, 3'h4, 3'h4, `FPDEC_OP_TANH));
      rdc(`FPDEC_OFF_DEC, 32'h00C48000, 32'h00CFFF80);
      $display("test same register done");
      fpdec_host_i.xfer(1'h0, 8'h18, 32'h0, q, e);
      chk(q, 32'h0, 32'hFFFFFFFF);
      chk({31'h0, e}, 32'h1, 32'h1);
      $display("test unmapped done");
      stop_test;
   end
endmodule
